// ### hdl/tcs_pkg.sv
package tcs_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] CTRL_THREE_OFS = 8'h30;
  localparam logic [7:0] CTRL_TWO_OFS = 8'h38;
  localparam logic [7:0] RX_INFO_TWO_OFS = 8'h31;
  localparam logic [7:0] CTRL_THREE_RST = 8'h00;
  localparam logic [7:0] CTRL_TWO_RST = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
  // ==========================================================
  // Common control two field positions
  localparam int TX_FRAME_MODE_BIT = 7;
  localparam int TX_ZERO_SUBST_BIT = 6;
  localparam int TX_SUBLOOP_BIT = 5;
  localparam int TX_STUFF_BIT = 4;
  localparam int RX_FRAME_MODE_BIT = 3;
  localparam int RX_ZERO_SUBST_BIT = 2;
  localparam int RX_SUBLOOP_BIT = 1;
  localparam int RX_DESTUFF_BIT = 0;
  // ==========================================================
  // Common control three field positions
  localparam int MIN_DELAY_BIT = 7;
  localparam int STORE_RESET_BIT = 6;
  localparam int PIN_FUNC_BIT = 5;
  localparam int SYNC_SKIP_BIT = 4;
  localparam int ENFORCE_BIT = 3;
  localparam int LOOP_DOWN_BIT = 2;
  localparam int LOOP_UP_BIT = 1;
  localparam int LINE_RESET_BIT = 0;
  // ==========================================================
  // Receive info two field positions
  localparam int TX_DENS_VIOL_BIT = 0;
  localparam int RX_DENS_VIOL_BIT = 1;
  // ==========================================================
  // Density rules and loop codes
  localparam int ZERO_RUN_MAX = 15;
  localparam int DENS_N_MAX = 23;
  localparam int HIST_LEN = 8 * (DENS_N_MAX + 1);
  localparam logic [2:0] LOOP_DOWN_LEN = 3'h3;
  localparam logic [2:0] LOOP_UP_LEN = 3'h5;
  // ==========================================================
  // Timing
  localparam int CLK_KHZ = 25000;
  localparam int RECOVER_MS = 40;
  localparam int RECOVER_CYCLES = RECOVER_MS * CLK_KHZ;
endpackage

// ### hdl/tcs_dens_mon.sv
`timescale 1ns/1ps
module tcs_dens_mon (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic bit_in,
  input wire logic bit_stb,
  output logic need_one,
  output logic viol
);
  localparam int HL = tcs_pkg::HIST_LEN;
  localparam int NM = tcs_pkg::DENS_N_MAX;

  typedef struct packed {
    logic [HL-1:0] hist;
    logic [4:0] zrun;
    logic [7:0] fill;
  } tcs_dm_t;

  tcs_dm_t st_reg;
  tcs_dm_t st_next;
  logic [NM:1] bad_now;
  logic [NM:1] bad_zero;

  function automatic logic [7:0] ones_in(input logic [HL-1:0] v,
                                         input int len);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < HL; i++)
    begin
      if (i < len)
      begin
        c = c + {7'h00, v[i]};
      end
    end
    return c;
  endfunction

  // ==========================================================
  // Window checks for every N
  for (genvar n = 1; n <= NM; n++)
  begin : g_win
    localparam int WL = 8 * (n + 1);
    assign bad_now[n] = (st_next.fill >= 8'(WL)) &&
      (ones_in(st_next.hist, WL) < 8'(n));
    assign bad_zero[n] = (st_reg.fill >= 8'(WL - 1)) &&
      (ones_in({st_reg.hist[HL-2:0], 1'b0}, WL) < 8'(n));
  end

  always_comb
  begin
    st_next = st_reg;
    if (bit_stb)
    begin
      st_next.hist = {st_reg.hist[HL-2:0], bit_in};
      st_next.zrun = bit_in ? 5'h00 :
        (st_reg.zrun == 5'h1F ? 5'h1F : st_reg.zrun + 5'h01);
      st_next.fill = (st_reg.fill == 8'(HL)) ? st_reg.fill :
        st_reg.fill + 8'h01;
    end
    need_one = (st_reg.zrun >= 5'(tcs_pkg::ZERO_RUN_MAX)) ||
      (|bad_zero);
    viol = bit_stb && ((!bit_in &&
      st_reg.zrun >= 5'(tcs_pkg::ZERO_RUN_MAX)) || (|bad_now));
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_reg <= '0;
    end
    else if (ce)
    begin
      st_reg <= st_next;
    end
  end
endmodule

// ### hdl/tcs_common_ctrl.sv
`timescale 1ns/1ps
// How it works
// - Frame mode bits pick D4 or ESF
// - Transmit zero-substitution enable drives coder
// - Receive zero-substitution enable drives decoder
// - Transmit subscriber-loop Fs loading enable
// - Receive subscriber-loop multiframe mode enable
// - Transmit link zero stuffer enable
// - Receive link zero destuffer enable
// - Minimum delay selects 32-bit store depth
// - Store reset acts on rising edge only
// - Shared pin shows sync loss or clock loss
// - Skip alternate multiframe sync pulses when allowed
// - Enforcer forces ones to meet density
// - Loop down sends repeating 001
// - Loop up sends repeating 00001
// - Framing bits kept; code runs while set
// - Line interface reset on rising edge only
// - Monitor zero runs and windowed ones density
// - Violations latch into receive info two
// - Latched status with write-read-write clearing
module tcs_common_ctrl #(
  parameter int RECOVER_CYCLES = tcs_pkg::RECOVER_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic tx_bit,
  input wire logic tx_bit_stb,
  input wire logic tx_fbit_slot,
  output logic tx_bit_out,
  output logic tx_bit_out_stb,
  input wire logic rx_bit,
  input wire logic rx_bit_stb,
  input wire logic rx_sync_lost,
  input wire logic tx_clock_lost,
  input wire logic rx_mf_pulse,
  input wire logic sync_mf_mode,
  input wire logic rx_store_en,
  output logic shared_pin,
  output logic rx_sync_out,
  output logic [7:0] ctrl_two,
  output logic [7:0] ctrl_three,
  output logic store_reset_pulse,
  output logic line_if_reset_pulse,
  output logic line_if_busy
);
  typedef struct packed {
    logic [7:0] ctl_two;
    logic [7:0] ctl_three;
    logic [7:0] rdata;
    logic [1:0] latch;
    logic [1:0] held;
    logic [19:0] recover;
    logic busy;
    logic store_rst_p;
    logic lir_p;
    logic [2:0] loop_pos;
    logic tx_out;
    logic tx_stb;
    logic rx_sync_lost_s1;
    logic rx_sync_lost_s2;
    logic tx_clock_lost_s1;
    logic tx_clock_lost_s2;
    logic mf_s1;
    logic mf_s2;
    logic mf_prev;
    logic skip;
    logic sync_out;
    logic pin;
  } tcs_st_t;

  tcs_st_t st_reg;
  tcs_st_t st_next;
  logic tx_need_one;
  logic tx_viol;
  logic rx_viol;
  logic [1:0] events;
  logic tx_pre;
  logic tx_fin;
  logic [2:0] loop_len;
  logic loop_on;
  logic mf_edge;
  logic [7:0] ctl_three_new;

  // ==========================================================
  // Density monitors
  tcs_dens_mon u_tx_mon (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .bit_in(tx_fin),
    .bit_stb(tx_bit_stb),
    .need_one(tx_need_one),
    .viol(tx_viol)
  );

  tcs_dens_mon u_rx_mon (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .bit_in(rx_bit),
    .bit_stb(rx_bit_stb),
    .need_one(),
    .viol(rx_viol)
  );

  // ==========================================================
  // Transmit stream path
  always_comb
  begin
    // Loop up wins if host sets both
    loop_on = st_reg.ctl_three[tcs_pkg::LOOP_UP_BIT] ||
      st_reg.ctl_three[tcs_pkg::LOOP_DOWN_BIT];
    loop_len = st_reg.ctl_three[tcs_pkg::LOOP_UP_BIT] ?
      tcs_pkg::LOOP_UP_LEN : tcs_pkg::LOOP_DOWN_LEN;
    if (tx_fbit_slot || !loop_on)
    begin
      tx_pre = tx_bit;
    end
    else
    begin
      tx_pre = (st_reg.loop_pos == loop_len - 3'h1);
    end
    tx_fin = tx_pre;
    if (st_reg.ctl_three[tcs_pkg::ENFORCE_BIT] && tx_need_one &&
        !tx_fbit_slot)
    begin
      tx_fin = 1'b1;
    end
  end

  assign events[tcs_pkg::TX_DENS_VIOL_BIT] = tx_viol;
  assign events[tcs_pkg::RX_DENS_VIOL_BIT] = rx_viol;
  assign mf_edge = st_reg.mf_s2 && !st_reg.mf_prev;
  assign ctl_three_new = bus_wdata;

  // ==========================================================
  // Next state
  always_comb
  begin
    st_next = st_reg;
    st_next.store_rst_p = 1'b0;
    st_next.lir_p = 1'b0;
    st_next.tx_stb = tx_bit_stb;
    st_next.rx_sync_lost_s1 = rx_sync_lost;
    st_next.rx_sync_lost_s2 = st_reg.rx_sync_lost_s1;
    st_next.tx_clock_lost_s1 = tx_clock_lost;
    st_next.tx_clock_lost_s2 = st_reg.tx_clock_lost_s1;
    st_next.mf_s1 = rx_mf_pulse;
    st_next.mf_s2 = st_reg.mf_s1;
    st_next.mf_prev = st_reg.mf_s2;
    st_next.pin = st_reg.ctl_three[tcs_pkg::PIN_FUNC_BIT] ?
      st_reg.tx_clock_lost_s2 : st_reg.rx_sync_lost_s2;
    if (tx_bit_stb)
    begin
      st_next.tx_out = tx_fin;
      if (!loop_on || st_reg.loop_pos >= loop_len - 3'h1)
      begin
        st_next.loop_pos = 3'h0;
      end
      else
      begin
        st_next.loop_pos = st_reg.loop_pos + 3'h1;
      end
    end
    st_next.sync_out = 1'b0;
    if (mf_edge)
    begin
      if (st_reg.ctl_three[tcs_pkg::SYNC_SKIP_BIT] && sync_mf_mode &&
          !rx_store_en)
      begin
        st_next.skip = !st_reg.skip;
        st_next.sync_out = !st_reg.skip;
      end
      else
      begin
        st_next.skip = 1'b0;
        st_next.sync_out = 1'b1;
      end
    end
    if (st_reg.recover != 20'h00000)
    begin
      st_next.recover = st_reg.recover - 20'h00001;
    end
    st_next.busy = (st_next.recover != 20'h00000);
    st_next.latch = st_reg.latch;
    if (bus_wr && bus_addr == tcs_pkg::CTRL_TWO_OFS)
    begin
      st_next.ctl_two = bus_wdata;
    end
    if (bus_wr && bus_addr == tcs_pkg::CTRL_THREE_OFS)
    begin
      st_next.ctl_three = ctl_three_new;
      st_next.store_rst_p = ctl_three_new[tcs_pkg::STORE_RESET_BIT] &&
        !st_reg.ctl_three[tcs_pkg::STORE_RESET_BIT];
      st_next.lir_p = ctl_three_new[tcs_pkg::LINE_RESET_BIT] &&
        !st_reg.ctl_three[tcs_pkg::LINE_RESET_BIT];
      if (st_next.lir_p)
      begin
        st_next.recover = 20'(RECOVER_CYCLES);
        st_next.busy = 1'b1;
      end
    end
    if (bus_wr && bus_addr == tcs_pkg::RX_INFO_TWO_OFS)
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (bus_wdata[i])
        begin
          st_next.held[i] = st_reg.latch[i];
          st_next.latch[i] = 1'b0;
        end
      end
    end
    st_next.latch = st_next.latch | events;
    if (bus_rd)
    begin
      case (bus_addr)
        tcs_pkg::CTRL_TWO_OFS: st_next.rdata = st_reg.ctl_two;
        tcs_pkg::CTRL_THREE_OFS: st_next.rdata = st_reg.ctl_three;
        tcs_pkg::RX_INFO_TWO_OFS: st_next.rdata = {6'h00, st_reg.held};
        default: st_next.rdata = tcs_pkg::RDATA_UNMAPPED;
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_reg <= '0;
      st_reg.ctl_two <= tcs_pkg::CTRL_TWO_RST;
      st_reg.ctl_three <= tcs_pkg::CTRL_THREE_RST;
    end
    else if (ce)
    begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Outputs
  assign bus_rdata = st_reg.rdata;
  assign tx_bit_out = st_reg.tx_out;
  assign tx_bit_out_stb = st_reg.tx_stb;
  assign shared_pin = st_reg.pin;
  assign rx_sync_out = st_reg.sync_out;
  assign ctrl_two = st_reg.ctl_two;
  assign ctrl_three = st_reg.ctl_three;
  assign store_reset_pulse = st_reg.store_rst_p;
  assign line_if_reset_pulse = st_reg.lir_p;
  assign line_if_busy = st_reg.busy;

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  ctrl_two_wr_a: assert property (ce && bus_wr &&
    bus_addr == tcs_pkg::CTRL_TWO_OFS |=>
    ctrl_two == $past(bus_wdata))
    else $error("control two not written");
  store_edge_a: assert property (store_reset_pulse |->
    ctrl_three[tcs_pkg::STORE_RESET_BIT] && !$past(ctrl_three[6]))
    else $error("store reset pulse without rising edge");
  line_edge_a: assert property (line_if_reset_pulse |=>
    !line_if_reset_pulse)
    else $error("line reset pulse too long");
  pin_mux_a: assert property (ce && $past(ce) && $past(ce, 2) &&
    $past(ce, 3) |-> shared_pin == ($past(ctrl_three[5]) ?
    $past(tx_clock_lost, 3) : $past(rx_sync_lost, 3)))
    else $error("shared pin wrong source");
  loop_frame_a: assert property (ce && tx_bit_stb && tx_fbit_slot &&
    !ctrl_three[3] |=> tx_bit_out == $past(tx_bit))
    else $error("framing bit overwritten");
  loop_down_a: assert property (ce && tx_bit_stb && !tx_fbit_slot &&
    !ctrl_three[3] && ctrl_three[2] && !ctrl_three[1] &&
    st_reg.loop_pos == 3'h0 |=> !tx_bit_out)
    else $error("loop down pattern wrong");
  enforce_a: assert property (ce && tx_bit_stb && ctrl_three[3] &&
    tx_need_one && !tx_fbit_slot |=> tx_bit_out)
    else $error("enforcer did not insert one");
  latch_set_a: assert property (ce && rx_viol |=>
    st_reg.latch[tcs_pkg::RX_DENS_VIOL_BIT])
    else $error("violation not latched");
  status_read_a: assert property (ce && bus_wr && bus_wdata[0] &&
    bus_addr == tcs_pkg::RX_INFO_TWO_OFS |=>
    st_reg.held[0] == $past(st_reg.latch[0]))
    else $error("status not refreshed");
  skip_a: assert property (rx_sync_out && $past(ctrl_three[4]) &&
    $past(sync_mf_mode) && !$past(rx_store_en) |-> st_reg.skip)
    else $error("skip toggle wrong");
  recover_a: assert property (line_if_reset_pulse |-> line_if_busy)
    else $error("recovery not started");

  loop_up_c: cover property (ctrl_three[1] && tx_bit_stb);
  skip_c: cover property (ctrl_three[4] && mf_edge);
  clear_c: cover property (bus_wr && bus_addr == tcs_pkg::RX_INFO_TWO_OFS);
  enforce_c: cover property (ctrl_three[3] && tx_need_one);
endmodule

// ### tb/tcs_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// Host processor on the parallel control port
module tcs_host_model (
  output logic [7:0] bus_addr,
  output logic [7:0] bus_wdata,
  output logic bus_wr,
  output logic bus_rd,
  input wire logic ref_clk,
  input wire logic [7:0] bus_rdata
);
  initial
  begin
    bus_addr = 8'h00;
    bus_wdata = 8'h00;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
  end

  // ========================================================
  // Register cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == tcs_pkg::CTRL_THREE_OFS && v[2] && v[1])
      v[2] = 1'b0;
    @(negedge ref_clk);
    bus_addr = a;
    bus_wdata = v;
    bus_wr = 1'b1;
    @(negedge ref_clk);
    bus_wr = 1'b0;
    bus_addr = ~a;
    bus_wdata = ~v;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge ref_clk);
    bus_rd = 1'b0;
    bus_addr = ~a;
    @(negedge ref_clk);
    d = bus_rdata;
  endtask

  // Mask write, read, masked write back
  task automatic poll(input logic [7:0] m, output logic [7:0] d);
    wr(tcs_pkg::RX_INFO_TWO_OFS, m);
    rd(tcs_pkg::RX_INFO_TWO_OFS, d);
    wr(tcs_pkg::RX_INFO_TWO_OFS, d & m);
  endtask
endmodule

// ### tb/t1_common_control_status_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %0t %h %h", $time, (g), (e)); end end
module t1_common_control_status_tb;
  localparam logic [7:0] C2 = tcs_pkg::CTRL_TWO_OFS;
  localparam logic [7:0] C3 = tcs_pkg::CTRL_THREE_OFS;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic tx_bit = 1'b0;
  logic tx_bit_stb = 1'b0;
  logic tx_fbit_slot = 1'b0;
  logic rx_bit = 1'b0;
  logic rx_bit_stb = 1'b0;
  logic rx_sync_lost = 1'b0;
  logic tx_clock_lost = 1'b0;
  logic rx_mf_pulse = 1'b0;
  logic sync_mf_mode = 1'b0;
  logic rx_store_en = 1'b0;
  logic [7:0] bus_addr, bus_wdata, bus_rdata, ctrl_two, ctrl_three, r, v;
  logic bus_wr, bus_rd, tx_bit_out, tx_bit_out_stb, shared_pin;
  logic rx_sync_out, store_reset_pulse, line_if_reset_pulse, line_if_busy;
  logic o, b, f, s, st, p, q;
  logic [29:0] ob;
  int failures = 0;
  int checked = 0;
  int seed = 32'h362d;
  int lr_n = 0;
  int st_n = 0;
  int sy_n = 0;
  int n0, i, k, ln, ones, run, mx;

  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    lr_n += int'(line_if_reset_pulse === 1'b1);
    st_n += int'(store_reset_pulse === 1'b1);
    sy_n += int'(rx_sync_out === 1'b1);
  end

  tcs_common_ctrl #(.RECOVER_CYCLES(20)) i_tcs_common_ctrl (
    .ref_clk, .rst, .ce(1'b1), .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
    .bus_rdata, .tx_bit, .tx_bit_stb, .tx_fbit_slot, .tx_bit_out,
    .tx_bit_out_stb, .rx_bit, .rx_bit_stb, .rx_sync_lost, .tx_clock_lost,
    .rx_mf_pulse, .sync_mf_mode, .rx_store_en, .shared_pin, .rx_sync_out,
    .ctrl_two, .ctrl_three, .store_reset_pulse, .line_if_reset_pulse,
    .line_if_busy
  );
  tcs_host_model i_tcs_host_model (
    .ref_clk, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata
  );

  // ========================================================
  // Helpers
  function automatic int exp_sync(input int n, input logic sk, input logic se);
    return (sk && !se) ? (n + 1) / 2 : n;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    i_tcs_host_model.wr(a, d);
  endtask

  task automatic send(input logic bi, input logic fi, output logic qo);
    @(negedge ref_clk);
    tx_bit = bi;
    rx_bit = bi;
    tx_fbit_slot = fi;
    tx_bit_stb = 1'b1;
    rx_bit_stb = 1'b1;
    @(negedge ref_clk);
    tx_bit_stb = 1'b0;
    rx_bit_stb = 1'b0;
    `CHK(tx_bit_out_stb, 1'b1)
    qo = tx_bit_out;
  endtask

  task automatic stat(input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    i_tcs_host_model.poll(m, d);
    `CHK(d, e)
  endtask

  task automatic conclude();
    if (failures == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge ref_clk);
    failures++;
    conclude();
  end

  // ========================================================
  // Main sequence
  initial
  begin
    tick(8);
    rst = 1'b0;
    i_tcs_host_model.rd(C2, r);
    `CHK(r, tcs_pkg::CTRL_TWO_RST)
    i_tcs_host_model.rd(8'h55, r);
    `CHK(r, tcs_pkg::RDATA_UNMAPPED)
    w(C2, 8'h00);
    w(C3, 8'h00);
    n0 = lr_n;
    w(C3, 8'h01);
    tick(2);
    `CHK(lr_n - n0, 1)
    `CHK(line_if_busy, 1'b1)
    for (i = 0; i < 100 && line_if_busy !== 1'b0; i++)
      tick(1);
    if (line_if_busy !== 1'b0)
    begin
      failures++;
      conclude();
    end
    w(C3, 8'h01);
    w(C3, 8'h00);
    w(C3, 8'h01);
    tick(2);
    `CHK(lr_n - n0, 2)
    n0 = st_n;
    w(C3, 8'h41);
    w(C3, 8'h41);
    w(C3, 8'h00);
    w(C3, 8'h40);
    tick(2);
    `CHK(st_n - n0, 2)
    repeat (8)
    begin
      v = 8'($random(seed));
      w(C2, v);
      i_tcs_host_model.rd(C2, r);
      `CHK(r, v)
      `CHK(ctrl_two, v)
      v = 8'($random(seed)) & 8'hF9;
      w(C3, v);
      i_tcs_host_model.rd(C3, r);
      `CHK(r, v)
      `CHK(ctrl_three, v)
    end
    for (k = 0; k < 4; k++)
    begin
      p = 1'($random(seed));
      q = 1'($random(seed));
      rx_sync_lost = p;
      tx_clock_lost = q;
      w(C3, k[0] ? 8'h20 : 8'h00);
      tick(5);
      `CHK(shared_pin, k[0] ? q : p)
    end
    sync_mf_mode = 1'b1;
    for (k = 0; k < 3; k++)
    begin
      s = (k != 1);
      st = (k == 2);
      rx_store_en = st;
      w(C3, s ? 8'h10 : 8'h00);
      n0 = sy_n;
      repeat (4)
      begin
        rx_mf_pulse = 1'b1;
        tick(2);
        rx_mf_pulse = 1'b0;
        tick(6);
      end
      tick(6);
      `CHK(sy_n - n0, exp_sync(4, s, st))
    end
    for (k = 0; k < 2; k++)
    begin
      ln = k ? tcs_pkg::LOOP_UP_LEN : tcs_pkg::LOOP_DOWN_LEN;
      w(C3, k ? 8'h02 : 8'h04);
      ones = 0;
      for (i = 0; i < 30; i++)
      begin
        f = (i == 12 || i == 13);
        b = f ? (i == 12) : 1'($random(seed));
        send(b, f, o);
        ob[i] = o;
        if (f)
          `CHK(o, b)
        if (i < ln)
          ones += o;
        if (i >= ln && !f && i - ln != 12 && i - ln != 13)
          `CHK(o, ob[i - ln])
      end
      `CHK(ones, 1)
    end
    w(C3, 8'h00);
    repeat (8)
    begin
      b = 1'($random(seed));
      send(b, 1'b0, o);
      `CHK(o, b)
    end
    repeat (20) send(1'b1, 1'b0, o);
    i_tcs_host_model.poll(8'h03, r);
    stat(8'h03, 8'h00);
    repeat (20) send(1'b0, 1'b0, o);
    stat(8'h01, 8'h01);
    stat(8'h02, 8'h02);
    stat(8'h03, 8'h00);
    w(C2, 8'h00);
    w(C3, 8'h08);
    run = 0;
    mx = 0;
    repeat (40)
    begin
      send(1'b0, 1'b0, o);
      run = o ? 0 : run + 1;
      mx = (run > mx) ? run : mx;
    end
    `CHK(mx <= tcs_pkg::ZERO_RUN_MAX, 1'b1)
    conclude();
  end
endmodule
